// File: verif/sync_serial_far_end.sv
// far-end synchronous device: shifter for a master port, or clock master on demand
// assumes the bench resolves both wires and sets the controls between frames
`timescale 1ns/1ps
module sync_serial_far_end (
  // resolved wires and clock polarity
  input  wire logic clkWire,
  input  wire logic dataWire,
  input  wire logic polarity,
  // drives
  output logic      clkOut,
  output logic      clkOe,
  output logic      dataOut,
  output logic      dataOe
);
  logic [8:0] sendChars [0:3];
  logic       sendEn;
  logic       rxBits [0:63];
  int         nBits, bitIdx, rxCnt;

  initial begin
    clkOut = 1'b0;
    clkOe = 1'b0;
    dataOut = 1'b0;
    sendEn = 1'b0;
    nBits = 8;
    bitIdx = 0;
    rxCnt = 0;
  end
  assign dataOe = sendEn;

  // change data on the leading edge so it is settled at the trailing one
  always @(clkWire) begin
    if (clkWire === ~polarity && sendEn) begin
      dataOut = sendChars[(bitIdx / nBits) % 4][bitIdx % nBits];
      bitIdx++;
    end else if (clkWire === polarity && rxCnt < 64) begin
      rxBits[rxCnt] = dataWire;
      rxCnt++;
    end
  end

  // clock idles at the polarity level between frames
  task master_clocks(input int n);
    // keep pin changes off the ref_clk sampling edges
    #7;
    for (int i = 0; i < n; i++) begin
      #100 clkOut = ~polarity;
      #100 clkOut = polarity;
    end
  endtask : master_clocks
endmodule : sync_serial_far_end

// File: verif/sync_serial_port_chk.sv
// assertions on the serial port's register bus and line drivers
// assumes register writes land at the edge where ack is high
`timescale 1ns/1ps
module sync_serial_port_chk
  import sync_serial_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  // wishbone slave
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // lines
  input wire logic        clockLineIn,
  input wire line_drive_t clockLine,
  input wire logic        dataLineIn,
  input wire line_drive_t dataLine
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // shadow of written control; hardware clears of single-receive are not mirrored
  logic [7:0]  tx_reg, rx_reg, baud_reg, lo_reg, hi_reg;
  logic        lastOut_reg, lastOe_reg;
  logic [19:0] runLen_reg;
  wire         wrHit    = ack_o && cyc_i && stb_i && we_i && sel_i[0];
  wire         portOn   = rx_reg[RX_PORT_ENABLE] && tx_reg[TX_SYNC_SELECT];
  wire         masterOn = portOn && tx_reg[TX_CLOCK_SOURCE];
  wire         txMode   = !rx_reg[RX_SINGLE] && !rx_reg[RX_CONTINUOUS] && tx_reg[TX_ENABLE];
  wire [15:0]  cfg      = {tx_reg, rx_reg};
  wire [16:0]  divSel   = baud_reg[BAUD_WIDE_DIV] ? {1'b0, hi_reg, lo_reg} : {9'h0, lo_reg};
  wire [16:0]  divPlus  = divSel + 17'h1;
  wire [18:0]  hExp     = tx_reg[TX_HIGH_SPEED] ? {2'b00, divPlus} : {divPlus, 2'b00};
  wire         leadEdge = clockLine.oe && lastOe_reg && (clockLine.out != lastOut_reg)
                          && (clockLine.out != baud_reg[BAUD_POLARITY]);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      {tx_reg, rx_reg, baud_reg, lo_reg, hi_reg} <= 40'h0;
      {lastOut_reg, lastOe_reg} <= 2'b00;
      runLen_reg <= 20'h0;
    end else begin
      if (wrHit && adr_i == OFS_TX_STATUS) tx_reg <= dat_i[7:0];
      if (wrHit && adr_i == OFS_RX_STATUS) rx_reg <= dat_i[7:0];
      if (wrHit && (adr_i == OFS_BAUD_ONE || adr_i == OFS_BAUD_TWO)) baud_reg <= dat_i[7:0];
      if (wrHit && adr_i == OFS_DIV_LOW) lo_reg <= dat_i[7:0];
      if (wrHit && adr_i == OFS_DIV_HIGH) hi_reg <= dat_i[7:0];
      lastOut_reg <= clockLine.out;
      lastOe_reg  <= clockLine.oe;
      if (clockLine.out != lastOut_reg) runLen_reg <= 20'h1;
      else if (runLen_reg != 20'hfffff) runLen_reg <= runLen_reg + 20'h1;
    end
  end

  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  property p_ack_next;
    s_req |=> ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_upper_zero;
    ack_o |-> dat_o[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
  property p_clk_oe;
    $stable(cfg) |-> clockLine.oe == masterOn;
  endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("clock driver mismatch");
  property p_slave_clk;
    $stable(cfg) && !tx_reg[TX_CLOCK_SOURCE] |-> !clockLine.oe;
  endproperty
  a_slave_clk: assert property (p_slave_clk) else $error("slave drives clock");
  property p_rx_data;
    $stable(cfg) && rx_reg[RX_CONTINUOUS] |-> !dataLine.oe;
  endproperty
  a_rx_data: assert property (p_rx_data) else $error("data driven in receive");
  property p_tx_data;
    $stable(cfg) && portOn && txMode |-> dataLine.oe;
  endproperty
  a_tx_data: assert property (p_tx_data) else $error("data not driven in transmit");
  property p_half;
    leadEdge |-> runLen_reg >= {1'b0, hExp};
  endproperty
  a_half: assert property (p_half) else $error("clock phase shorter than divider");
endmodule : sync_serial_port_chk

// File: verif/sync_serial_port_test.sv
// self-checking bench for the synchronous serial port
// assumes the far-end model and the checker bound below
`timescale 1ns/1ps
module sync_serial_port_test
  import sync_serial_pkg::*;
;
  localparam logic [7:0] OFS_TAB [0:6] = '{OFS_RX_STATUS, OFS_DIV_LOW, OFS_DIV_HIGH,
                                          OFS_TX_DATA, OFS_RX_DATA, OFS_FLAGS, 8'h24};
  localparam logic [7:0] RST_TAB [0:6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
  logic        ref_clk, nrst, cyc, stb, we, floatLine, pol, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datI, datO;
  line_drive_t clockLine, dataLine;
  logic        clkWire, dataWire, pClkOut, pClkOe, pDataOut, pDataOe;
  int          error_cnt, n_compared, n;

  // undriven wires change every cycle so nothing rests on a stale level
  assign clkWire  = clockLine.oe ? clockLine.out : (pClkOe ? pClkOut : floatLine);
  assign dataWire = dataLine.oe ? dataLine.out : (pDataOe ? pDataOut : floatLine);
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) floatLine <= ~floatLine;

  sync_serial_port dut_u (.ref_clk(ref_clk), .nrst(nrst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datI), .dat_o(datO), .ack_o(ack),
    .clockLineIn(clkWire), .clockLine(clockLine), .dataLineIn(dataWire),
    .dataLine(dataLine));
  sync_serial_far_end partner_u (.clkWire(clkWire), .dataWire(dataWire), .polarity(pol),
    .clkOut(pClkOut), .clkOe(pClkOe), .dataOut(pDataOut), .dataOe(pDataOe));

  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic bail;
    error_cnt++;
    $display("FAIL at %0t: wait ran out", $time);
    end_of_test();
  endtask : bail
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
    int i;
    @(posedge ref_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; datI <= {24'h0, d}; sel <= 4'h1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (ack !== 1'b1 && i < 16);
    q = datO;
    cyc <= 1'b0; stb <= 1'b0;
    if (ack !== 1'b1) bail();
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    check(q, {24'h0, exp});
  endtask : rd
  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    logic [31:0] q;
    int i;
    i = 0;
    do begin
      xfer(1'b0, a, 8'h00, q);
      i++;
    end while (q[b] !== v && i < 400);
    if (q[b] !== v) bail();
  endtask : wait_bit
  task automatic arm(input int nb);
    // let the line settle after a driver change before counting edges
    @(posedge ref_clk);
    partner_u.nBits = nb;
    partner_u.bitIdx = 0;
    partner_u.rxCnt = 0;
  endtask : arm
  function automatic logic [8:0] char_at(input int base, input int nb);
    logic [8:0] v;
    v = 9'h0;
    for (int k = 0; k < nb; k++) v[k] = partner_u.rxBits[base + k];
    return v;
  endfunction : char_at

  initial begin
    ref_clk = 1'b0; nrst = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
    sel = 4'h0; datI = 32'h0; floatLine = 1'b0; pol = 1'b0; error_cnt = 0; n_compared = 0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++) rd(OFS_TAB[i], RST_TAB[i]);
    wr(8'h24, 8'hff);
    rd(8'h24, 8'h00);
    wr(OFS_DIV_HIGH, 8'h5a);
    rd(OFS_DIV_HIGH, 8'h5a);
    wr(OFS_DIV_LOW, 8'h03);
    rd(OFS_DIV_LOW, 8'h03);
    wr(OFS_TX_DATA, 8'h77);
    rd(OFS_FLAGS, 8'h02);
    // master transmit: plain, then idle-high clock with ninth bit
    for (int c = 0; c < 2; c++) begin
      wr(OFS_RX_STATUS, 8'h00);
      pol = c[0];
      wr(OFS_BAUD_ONE, c[0] ? 8'h10 : 8'h00);
      wr(OFS_TX_STATUS, c[0] ? 8'hf5 : 8'hb4);
      wr(OFS_RX_STATUS, 8'h80);
      arm(8 + c);
      wr(OFS_TX_DATA, 8'ha5);
      wr(OFS_TX_DATA, 8'h3c);
      rd(OFS_FLAGS, 8'h00);
      wait_bit(OFS_TX_STATUS, TX_SHIFTER_EMPTY, 1'b1);
      repeat (4) @(posedge ref_clk);
      check(partner_u.rxCnt, 2 * (8 + c));
      check(char_at(0, 8 + c), {c[0], 8'ha5});
      check(char_at(8 + c, 8 + c), {c[0], 8'h3c});
      check(clockLine.out, pol);
      rd(OFS_FLAGS, 8'h02);
    end
    wr(OFS_RX_STATUS, 8'h00);
    pol = 1'b0;
    wr(OFS_BAUD_ONE, 8'h00);
    // master single receive
    wr(OFS_TX_STATUS, 8'h94);
    wr(OFS_RX_STATUS, 8'h80);
    arm(8);
    partner_u.sendChars = '{9'h096, 9'h096, 9'h096, 9'h096};
    partner_u.sendEn = 1'b1;
    wr(OFS_RX_STATUS, 8'ha0);
    wait_bit(OFS_FLAGS, FLAG_RECEIVE, 1'b1);
    repeat (60) @(posedge ref_clk);
    check(partner_u.rxCnt, 8);
    rd(OFS_RX_STATUS, 8'h80);
    rd(OFS_RX_DATA, 8'h96);
    rd(OFS_FLAGS, 8'h02);
    // continuous nine-bit reception into overrun
    partner_u.sendChars = '{9'h1a5, 9'h03c, 9'h1c3, 9'h0ff};
    wr(OFS_RX_STATUS, 8'hc0);
    arm(9);
    wr(OFS_RX_STATUS, 8'hf0);
    wait_bit(OFS_RX_STATUS, RX_OVERRUN, 1'b1);
    rd(OFS_RX_STATUS, 8'hd3);
    rd(OFS_RX_DATA, 8'ha5);
    rd(OFS_RX_STATUS, 8'hd2);
    rd(OFS_RX_DATA, 8'h3c);
    rd(OFS_FLAGS, 8'h02);
    wr(OFS_RX_STATUS, 8'hc0);
    // empty fifo still shows the ninth bit of the stale head entry
    rd(OFS_RX_STATUS, 8'hc1);
    // three single receptions overrun, cleared by a data read
    wr(OFS_RX_STATUS, 8'h80);
    arm(8);
    for (int k = 0; k < 3; k++) begin
      wr(OFS_RX_STATUS, 8'ha0);
      wait_bit(OFS_RX_STATUS, RX_SINGLE, 1'b0);
    end
    rd(OFS_RX_STATUS, 8'h82);
    rd(OFS_RX_DATA, 8'ha5);
    rd(OFS_RX_STATUS, 8'h80);
    rd(OFS_RX_DATA, 8'h3c);
    // abort mid-character
    arm(8);
    wr(OFS_RX_STATUS, 8'h90);
    for (int i = 0; i < 400 && partner_u.rxCnt < 4; i++) @(posedge ref_clk);
    wr(OFS_RX_STATUS, 8'h80);
    repeat (4) @(posedge ref_clk);
    n = partner_u.rxCnt;
    repeat (100) @(posedge ref_clk);
    check(partner_u.rxCnt, n);
    rd(OFS_FLAGS, 8'h02);
    check(clockLine.out, 1'b0);
    // slave receive on a far-end clock
    wr(OFS_RX_STATUS, 8'h00);
    wr(OFS_TX_STATUS, 8'h10);
    partner_u.clkOut = 1'b0;
    partner_u.clkOe = 1'b1;
    partner_u.sendChars = '{9'h05c, 9'h05c, 9'h05c, 9'h05c};
    wr(OFS_RX_STATUS, 8'h80);
    arm(8);
    wr(OFS_RX_STATUS, 8'h90);
    partner_u.master_clocks(8);
    repeat (20) @(posedge ref_clk);
    check(clockLine.oe, 1'b0);
    check(partner_u.bitIdx, 8);
    rd(OFS_FLAGS, 8'h03);
    rd(OFS_RX_DATA, 8'h5c);
    partner_u.clkOe = 1'b0;
    end_of_test();
  end
endmodule : sync_serial_port_test

bind sync_serial_port sync_serial_port_chk chk_u (.ref_clk(ref_clk), .nrst(nrst),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .clockLineIn(clockLineIn), .clockLine(clockLine),
  .dataLineIn(dataLineIn), .dataLine(dataLine));

// File: verilog/sync_serial_pkg.sv
// constants, register map and carrier types of the synchronous serial port
// assumes a 32-bit classic wishbone host with byte-wide registers in the low lane
package sync_serial_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_TX_STATUS  = 8'h00;
  localparam logic [7:0] OFS_RX_STATUS  = 8'h04;
  localparam logic [7:0] OFS_BAUD_ONE   = 8'h08;
  localparam logic [7:0] OFS_BAUD_TWO   = 8'h0c;
  localparam logic [7:0] OFS_DIV_LOW    = 8'h10;
  localparam logic [7:0] OFS_DIV_HIGH   = 8'h14;
  localparam logic [7:0] OFS_TX_DATA    = 8'h18;
  localparam logic [7:0] OFS_RX_DATA    = 8'h1c;
  localparam logic [7:0] OFS_FLAGS      = 8'h20;

  // transmit_status_control fields
  localparam int TX_CLOCK_SOURCE  = 7;
  localparam int TX_NINTH_EN      = 6;
  localparam int TX_ENABLE        = 5;
  localparam int TX_SYNC_SELECT   = 4;
  localparam int TX_HIGH_SPEED    = 2;
  localparam int TX_SHIFTER_EMPTY = 1;
  localparam int TX_NINTH_BIT     = 0;
  localparam logic [7:0] TX_WRITE_MASK = 8'hf5;

  // receive_status_control fields
  localparam int RX_PORT_ENABLE   = 7;
  localparam int RX_NINTH_EN      = 6;
  localparam int RX_SINGLE        = 5;
  localparam int RX_CONTINUOUS    = 4;
  localparam int RX_OVERRUN       = 1;
  localparam int RX_NINTH_BIT     = 0;
  localparam logic [7:0] RX_WRITE_MASK = 8'hf0;

  // baud control fields
  localparam int BAUD_RX_IDLE     = 6;
  localparam int BAUD_POLARITY    = 4;
  localparam int BAUD_WIDE_DIV    = 3;
  localparam logic [7:0] BAUD_WRITE_MASK = 8'h18;

  // flags register fields
  localparam int FLAG_RECEIVE     = 0;
  localparam int FLAG_TRANSMIT    = 1;

  // reset values and counts
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [3:0] LAST_BIT_EIGHT = 4'd7;
  localparam logic [3:0] LAST_BIT_NINE  = 4'd8;
  localparam logic [1:0] FIFO_DEPTH     = 2'd2;

  typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_RX} eng_state_t;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } rx_char_t;

  typedef struct packed {
    logic out;
    logic oe;
  } line_drive_t;

endpackage : sync_serial_pkg

// File: verilog/sync_serial_port.sv
// synchronous half-duplex serial port, master or slave, behind a wishbone slave
// assumes clockLineIn/dataLineIn are asynchronous pins; the bench resolves the wires
`timescale 1ns/1ps

// What this block does
// - master single receive clocks one character, then clears single-receive
// - master continuous receive clocks characters until continuous-receive clears
// - clearing continuous-receive mid character stops clock, drops partial character
// - both receive enables set: single clears after first, continuous continues
// - received data sampled at trailing shift clock edge into receive shifter
// - complete character moves into two-entry fifo, receive flag raised
// - receive data shows oldest entry low byte; flag holds while entries unread
// - third character with full fifo sets overrun, keeps data, blocks reception
// - overrun in single receive mode clears on receive data read
// - overrun in continuous mode clears by dropping continuous or port enable
// - nine-bit mode shifts nine bits, status shows oldest entry ninth bit
// - slave takes shift clock from line and never drives clock line
// - slave moves one bit per clock, data changes on leading edge
// - sync select, clock source, receive enables and port enable pick mode
// - master receive never drives the data line
// - polarity bit sets clock idle level and edge on which data changes
// - transmit byte waits for shifter to finish, loads at once if empty
// - master drives one clock per data bit, no start or stop bits
module sync_serial_port
  import sync_serial_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // clock line
  input  wire logic        clockLineIn,
  output line_drive_t      clockLine,
  // data line
  input  wire logic        dataLineIn,
  output line_drive_t      dataLine
);

  function automatic logic [3:0] lastBit(input logic nine);
    lastBit = nine ? LAST_BIT_NINE : LAST_BIT_EIGHT;
  endfunction : lastBit

  // control registers
  logic [7:0]  txCtrl_reg;
  logic [7:0]  rxCtrl_reg;
  logic [7:0]  rxCtrl_next;
  logic [7:0]  baudCtrl_reg;
  logic [7:0]  divLow_reg;
  logic [7:0]  divHigh_reg;
  // bus
  logic        ack_reg;
  logic [31:0] datOut_reg;
  logic        popPending_reg;
  // pins
  logic [1:0]  clkSync_reg;
  logic [1:0]  datSync_reg;
  logic        clkPrev_reg;
  // engine
  eng_state_t  state_reg;
  eng_state_t  state_next;
  logic [3:0]  bitCnt_reg;
  logic [8:0]  txShift_reg;
  logic [8:0]  rxShift_reg;
  logic [8:0]  rxWord;
  logic        txOut_reg;
  logic        txBufValid_reg;
  logic [7:0]  txBuf_reg;
  logic [17:0] divCnt_reg;
  logic        phase_reg;
  // receive fifo
  rx_char_t    fifo_reg [2];
  logic        head_reg;
  logic [1:0]  count_reg;
  logic        overrun_reg;
  logic        overrunByRead_reg;

  // field decode
  wire clockSourceMaster = txCtrl_reg[TX_CLOCK_SOURCE];
  wire ninthTxEnable     = txCtrl_reg[TX_NINTH_EN];
  wire transmitEnable    = txCtrl_reg[TX_ENABLE];
  wire syncSelect        = txCtrl_reg[TX_SYNC_SELECT];
  wire highSpeedSelect   = txCtrl_reg[TX_HIGH_SPEED];
  wire transmitNinthBit  = txCtrl_reg[TX_NINTH_BIT];
  wire portEnable        = rxCtrl_reg[RX_PORT_ENABLE];
  wire ninthRxEnable     = rxCtrl_reg[RX_NINTH_EN];
  wire singleRxEnable    = rxCtrl_reg[RX_SINGLE];
  wire contRxEnable      = rxCtrl_reg[RX_CONTINUOUS];
  wire clockIdlePolarity = baudCtrl_reg[BAUD_POLARITY];
  wire wideDividerSelect = baudCtrl_reg[BAUD_WIDE_DIV];

  // mode selection; single-receive starts reception only in the master, but blocks transmit in the slave too
  wire portOn  = portEnable & syncSelect;
  wire rxMode  = contRxEnable | (clockSourceMaster & singleRxEnable);
  wire txMode  = ~singleRxEnable & ~contRxEnable & transmitEnable;
  wire rxAllow = portOn & rxMode & ~overrun_reg;

  // bus decode
  wire reqNew   = cyc_i & stb_i & ~ack_reg;
  wire busFire  = cyc_i & stb_i & ack_reg;
  wire wrFire   = busFire & we_i & sel_i[0];
  wire selTx    = (adr_i == OFS_TX_STATUS);
  wire selRx    = (adr_i == OFS_RX_STATUS);
  wire selBaud  = (adr_i == OFS_BAUD_ONE) | (adr_i == OFS_BAUD_TWO);
  wire selLow   = (adr_i == OFS_DIV_LOW);
  wire selHigh  = (adr_i == OFS_DIV_HIGH);
  wire selTxDat = (adr_i == OFS_TX_DATA);
  wire selRxDat = (adr_i == OFS_RX_DATA);
  wire selFlags = (adr_i == OFS_FLAGS);
  wire popFire  = busFire & popPending_reg;

  // status
  rx_char_t oldest;
  assign oldest = fifo_reg[head_reg];
  wire receiveFlag      = (count_reg != 2'd0);
  wire transmitFlag     = ~txBufValid_reg;
  wire shifterEmptyFlag = (state_reg != ST_TX);
  wire receiverIdleFlag = (state_reg != ST_RX);

  logic [7:0] readMux;
  always_comb begin
    readMux = 8'h00;
    if (selTx) begin
      readMux = txCtrl_reg;
      readMux[TX_SHIFTER_EMPTY] = shifterEmptyFlag;
    end else if (selRx) begin
      readMux = rxCtrl_reg;
      readMux[RX_OVERRUN] = overrun_reg;
      readMux[RX_NINTH_BIT] = oldest.ninth;
    end else if (selBaud) begin
      readMux = baudCtrl_reg;
      readMux[BAUD_RX_IDLE] = receiverIdleFlag;
    end else if (selLow) begin
      readMux = divLow_reg;
    end else if (selHigh) begin
      readMux = divHigh_reg;
    end else if (selRxDat) begin
      readMux = oldest.data;
    end else if (selFlags) begin
      readMux[FLAG_RECEIVE] = receiveFlag;
      readMux[FLAG_TRANSMIT] = transmitFlag;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = datOut_reg;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg        <= 1'b0;
      datOut_reg     <= 32'h0000_0000;
      popPending_reg <= 1'b0;
    end else begin
      ack_reg <= reqNew;
      if (reqNew) begin
        datOut_reg     <= {24'h00_0000, readMux};
        popPending_reg <= ~we_i & selRxDat & receiveFlag;
      end
    end
  end

  // pin synchronisers and slave edge detection
  wire clkPin     = clkSync_reg[1];
  wire datPin     = datSync_reg[1];
  wire slaveLead  = (clkPin ^ clockIdlePolarity) & ~(clkPrev_reg ^ clockIdlePolarity);
  wire slaveTrail = ~(clkPin ^ clockIdlePolarity) & (clkPrev_reg ^ clockIdlePolarity);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clkSync_reg <= 2'b00;
      datSync_reg <= 2'b00;
      clkPrev_reg <= 1'b0;
    end else begin
      clkSync_reg <= {clkSync_reg[0], clockLineIn};
      datSync_reg <= {datSync_reg[0], dataLineIn};
      clkPrev_reg <= clkPin;
    end
  end

  // master shift clock: half period is (n+1) clocks, times four without high speed
  wire [15:0] divValue  = wideDividerSelect ? {divHigh_reg, divLow_reg}
                                            : {8'h00, divLow_reg};
  wire [17:0] divReload = highSpeedSelect ? {2'b00, divValue}
                                          : {divValue, 2'b11};
  wire masterRun   = portOn & clockSourceMaster & (state_reg != ST_IDLE);
  wire divTick     = masterRun & (divCnt_reg == 18'h0_0000);
  wire masterLead  = divTick & ~phase_reg;
  wire masterTrail = divTick & phase_reg;
  wire leadEv      = clockSourceMaster ? masterLead : slaveLead;
  wire trailEv     = clockSourceMaster ? masterTrail : slaveTrail;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      divCnt_reg <= 18'h0_0000;
      phase_reg  <= 1'b0;
    end else if (!masterRun) begin
      divCnt_reg <= divReload;
      phase_reg  <= 1'b0;
    end else if (divTick) begin
      divCnt_reg <= divReload;
      phase_reg  <= ~phase_reg;
    end else begin
      divCnt_reg <= divCnt_reg - 18'h0_0001;
    end
  end

  // idle level follows polarity; active phase is the opposite level
  assign clockLine.out = phase_reg ^ clockIdlePolarity;
  assign clockLine.oe  = portOn & clockSourceMaster;
  assign dataLine.out  = txOut_reg;
  assign dataLine.oe   = portOn & txMode;

  // shift engine
  wire txLast  = (bitCnt_reg == lastBit(ninthTxEnable));
  wire rxLast  = (bitCnt_reg == lastBit(ninthRxEnable));
  wire txWrite = wrFire & selTxDat & portOn & transmitEnable & ~txBufValid_reg;
  wire txDone  = (state_reg == ST_TX) & trailEv & txLast;
  wire txLoad  = portOn & txMode & txBufValid_reg
               & ((state_reg == ST_IDLE) | txDone);
  wire rxDone  = (state_reg == ST_RX) & rxAllow & trailEv & rxLast;
  wire fifoFull = (count_reg == FIFO_DEPTH);
  wire push     = rxDone & (~fifoFull | popFire);
  wire overrunSet = rxDone & fifoFull & ~popFire;

  always_comb begin
    rxWord = rxShift_reg;
    rxWord[bitCnt_reg] = datPin;
    if (!ninthRxEnable) begin
      rxWord[8] = 1'b0;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (txLoad) begin
          state_next = ST_TX;
        end else if (rxAllow) begin
          state_next = ST_RX;
        end
      end
      ST_TX: begin
        if (!(portOn & txMode)) begin
          state_next = ST_IDLE;
        end else if (txDone && !txLoad) begin
          state_next = ST_IDLE;
        end
      end
      ST_RX: begin
        if (!rxAllow) begin
          state_next = ST_IDLE;
        end else if (rxDone && (!contRxEnable || overrunSet)) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= ST_IDLE;
      bitCnt_reg  <= 4'd0;
      txShift_reg <= 9'h000;
      rxShift_reg <= 9'h000;
      txOut_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (txLoad) begin
        txShift_reg <= {transmitNinthBit, txBuf_reg};
        bitCnt_reg  <= 4'd0;
      end else if (state_next != state_reg || state_reg == ST_IDLE) begin
        bitCnt_reg  <= 4'd0;
        rxShift_reg <= 9'h000;
      end else if (trailEv) begin
        if (rxDone) begin
          bitCnt_reg  <= 4'd0;
          rxShift_reg <= 9'h000;
        end else begin
          bitCnt_reg <= bitCnt_reg + 4'd1;
          if (state_reg == ST_RX) begin
            rxShift_reg <= rxWord;
          end
        end
      end
      // data changes on the leading edge so it is steady at the trailing one
      if (state_reg == ST_TX && leadEv) begin
        txOut_reg <= txShift_reg[bitCnt_reg];
      end
    end
  end

  // transmit holding register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      txBufValid_reg <= 1'b0;
      txBuf_reg      <= 8'h00;
    end else if (!portOn || !transmitEnable) begin
      txBufValid_reg <= 1'b0;
    end else if (txWrite) begin
      txBufValid_reg <= 1'b1;
      txBuf_reg      <= dat_i[7:0];
    end else if (txLoad) begin
      txBufValid_reg <= 1'b0;
    end
  end

  // receive fifo; a write while full is dropped unless a pop lands in the same cycle, no unread data is overwritten
  wire       tailIdx = head_reg ^ count_reg[0];
  rx_char_t  newChar;
  assign newChar = '{ninth: rxWord[8], data: rxWord[7:0]};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      head_reg    <= 1'b0;
      count_reg   <= 2'd0;
      fifo_reg[0] <= '0;
      fifo_reg[1] <= '0;
    end else if (!portOn) begin
      head_reg  <= 1'b0;
      count_reg <= 2'd0;
    end else begin
      if (push) begin
        // a pop in the same cycle frees the head, which tailIdx names when full
        fifo_reg[tailIdx] <= newChar;
      end
      if (popFire) begin
        head_reg <= ~head_reg;
      end
      if (push && !popFire) begin
        count_reg <= count_reg + 2'd1;
      end else if (popFire && !push) begin
        count_reg <= count_reg - 2'd1;
      end
    end
  end

  // overrun: remember which mode it came from to pick the way it is cleared
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      overrun_reg       <= 1'b0;
      overrunByRead_reg <= 1'b0;
    end else if (!portOn) begin
      overrun_reg <= 1'b0;
    end else if (overrunSet) begin
      overrun_reg       <= 1'b1;
      overrunByRead_reg <= ~contRxEnable;
    end else if (overrunByRead_reg && popFire) begin
      overrun_reg <= 1'b0;
    end else if (!overrunByRead_reg && !contRxEnable) begin
      overrun_reg <= 1'b0;
    end
  end

  // control register writes; hardware clears single-receive after one character
  always_comb begin
    rxCtrl_next = rxCtrl_reg;
    if (rxDone) begin
      rxCtrl_next[RX_SINGLE] = 1'b0;
    end
    if (wrFire && selRx) begin
      rxCtrl_next = dat_i[7:0] & RX_WRITE_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      txCtrl_reg   <= CTRL_RESET;
      rxCtrl_reg   <= CTRL_RESET;
      baudCtrl_reg <= CTRL_RESET;
      divLow_reg   <= CTRL_RESET;
      divHigh_reg  <= CTRL_RESET;
    end else begin
      rxCtrl_reg <= rxCtrl_next;
      if (wrFire && selTx) begin
        txCtrl_reg <= dat_i[7:0] & TX_WRITE_MASK;
      end
      if (wrFire && selBaud) begin
        baudCtrl_reg <= dat_i[7:0] & BAUD_WRITE_MASK;
      end
      if (wrFire && selLow) begin
        divLow_reg <= dat_i[7:0];
      end
      if (wrFire && selHigh) begin
        divHigh_reg <= dat_i[7:0];
      end
    end
  end

endmodule : sync_serial_port
